// file: srw_consts.vh
// constants for the system restart watchdog
`ifndef SRW_CONSTS_VH
`define SRW_CONSTS_VH
`define SRW_CLK_HZ 32'd100_000_000
`define SRW_SEL_DISABLE 2'h0
`define SRW_SEL_ENABLE 2'h1
`define SRW_BOOT_OFF 2'h0
`define SRW_BOOT_30 2'h1
`define SRW_BOOT_60 2'h2
`define SRW_BOOT_90 2'h3
`define SRW_T30_S 8'h1e
`define SRW_T60_S 8'h3c
`define SRW_T90_S 8'h5a
`define SRW_ACT_RESET 1'b0
`define SRW_ACT_NMI 1'b1
`define SRW_RESTART_CYCLES 8'h10
`define SRW_NO_SECS 8'h00
`define SRW_MIN_SECS 8'h01
`define SRW_ONE_SEC 8'h01
`define SRW_LAST_SEC 8'h01
`define SRW_HOLD_STEP 8'h01
`define SRW_HOLD_LAST 8'h01
`endif

// file: srw_tick.v
// one-second tick generator for the watchdog
`timescale 1ns/1ps
module srw_tick
#(
   parameter CYCLES_PER_SEC = 100_000_000
)
(
   input wire clock,
   input wire nrst,
   input wire clear,
   output wire tick
);
   reg [31:0] cnt_reg;
   wire [31:0] cnt_next;
   wire [31:0] last = CYCLES_PER_SEC - 1;
   assign tick = (cnt_reg == last);
   assign cnt_next = (clear || tick) ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         cnt_reg <= 32'h0000_0000;
      else
         cnt_reg <= cnt_next;
   end
endmodule

// file: srw_watchdog.v
// system restart watchdog: boot arming, software control, restart output
// Functional notes
// - an unserviced expiry forces a restart of the whole system, or only an NMI pulse when the jumper selects NMI.
// - a boot setting arms the watchdog before boot with 30, 60 or 90 seconds, or leaves it off.
// - software may start, stop or retrigger the count.
// - a board jumper selects the expiry action.
// - selector 00 disables and 01 enables the watchdog.
// - the run-time timeout is 1 to 255 whole seconds from an eight-bit value.
`timescale 1ns/1ps
`include "srw_consts.vh"
module srw_watchdog
#(
   parameter CYCLES_PER_SEC = 100_000_000,
   parameter RESTART_CYCLES = 16
)
(
   input wire clock,
   input wire nrst,
   input wire [1:0] boot_sel,
   input wire action_jumper,
   input wire ctrl_valid,
   input wire [1:0] ctrl_sel,
   input wire [7:0] ctrl_secs,
   input wire retrigger,
   output reg sys_restart,
   output reg nmi_pulse,
   output reg running,
   output reg [7:0] secs_left
);
   localparam ST_BOOT = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_HOLD = 3'b100;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [7:0] count_reg;
   reg [7:0] count_next;
   reg [7:0] load_reg;
   reg [7:0] load_next;
   reg run_reg;
   reg run_next;
   reg [7:0] hold_reg;
   reg [7:0] hold_next;
   reg fire;
   reg tick_clr;
   wire tick;
   wire expire_now;
   wire [31:0] hold_full;
   wire [7:0] hold_len;

   // ----------------------------------------
   // boot timeout decode
   // ----------------------------------------
   function [7:0] boot_secs;
      input [1:0] sel;
      begin
         case (sel)
            `SRW_BOOT_30: boot_secs = `SRW_T30_S;
            `SRW_BOOT_60: boot_secs = `SRW_T60_S;
            `SRW_BOOT_90: boot_secs = `SRW_T90_S;
            default: boot_secs = `SRW_NO_SECS;
         endcase
      end
   endfunction

   // ----------------------------------------
   // run-time timeout clamp
   // ----------------------------------------
   function [7:0] clamp_secs;
      input [7:0] secs;
      begin
         if (secs == `SRW_NO_SECS)
            clamp_secs = `SRW_MIN_SECS;
         else
            clamp_secs = secs;
      end
   endfunction

   // ----------------------------------------
   // one-second prescaler
   // ----------------------------------------
   srw_tick #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) srw_tick_i
   (
      .clock(clock),
      .nrst(nrst),
      .clear(tick_clr),
      .tick(tick)
   );

   // ----------------------------------------
   // expiry and hold length
   // ----------------------------------------
   // last second runs out
   assign expire_now = run_reg && tick && (count_reg == `SRW_LAST_SEC);
   assign hold_full = RESTART_CYCLES;
   assign hold_len = hold_full[7:0];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always @*
   begin
      state_next = state_reg;
      count_next = count_reg;
      load_next = load_reg;
      run_next = run_reg;
      fire = 1'b0;
      tick_clr = 1'b0;
      case (state_reg)
         ST_BOOT:
         begin
            load_next = boot_secs(boot_sel);
            count_next = boot_secs(boot_sel);
            run_next = (boot_sel != `SRW_BOOT_OFF);
            tick_clr = 1'b1;
            state_next = ST_RUN;
         end
         ST_RUN:
         begin
            if (ctrl_valid && ctrl_sel == `SRW_SEL_DISABLE)
            begin
               run_next = 1'b0;
            end
            else if (ctrl_valid && ctrl_sel == `SRW_SEL_ENABLE)
            begin
               load_next = clamp_secs(ctrl_secs);
               count_next = clamp_secs(ctrl_secs);
               run_next = 1'b1;
               tick_clr = 1'b1;
            end
            else if (retrigger && run_reg)
            begin
               count_next = load_reg;
               tick_clr = 1'b1;
            end
            else if (expire_now)
            begin
               fire = 1'b1;
               run_next = 1'b0;
               count_next = `SRW_NO_SECS;
               if (action_jumper == `SRW_ACT_RESET)
                  state_next = ST_HOLD;
            end
            else if (run_reg && tick)
            begin
               count_next = count_reg - `SRW_ONE_SEC;
            end
         end
         ST_HOLD:
         begin
            if (hold_reg == `SRW_HOLD_LAST)
               state_next = ST_BOOT;
         end
         default:
         begin
            state_next = ST_BOOT;
         end
      endcase
   end

   // ----------------------------------------
   // restart hold counter
   // ----------------------------------------
   always @*
   begin
      hold_next = hold_reg;
      if (fire)
         hold_next = hold_len;
      else if (state_reg == ST_HOLD)
         hold_next = hold_reg - `SRW_HOLD_STEP;
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= ST_BOOT;
         count_reg <= 8'h00;
         load_reg <= 8'h00;
         run_reg <= 1'b0;
         hold_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
         load_reg <= load_next;
         run_reg <= run_next;
         hold_reg <= hold_next;
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sys_restart <= 1'b0;
         nmi_pulse <= 1'b0;
         running <= 1'b0;
         secs_left <= 8'h00;
      end
      else
      begin
         sys_restart <= (state_next == ST_HOLD);
         nmi_pulse <= fire && (action_jumper == `SRW_ACT_NMI);
         running <= run_next;
         secs_left <= count_next;
      end
   end
endmodule

// file: srw_watchdog_checker.sv
// concurrent checks on the watchdog ports
`timescale 1ns/1ps
module srw_watchdog_checker
(
   input wire clock,
   input wire nrst,
   input wire action_jumper,
   input wire ctrl_valid,
   input wire sys_restart,
   input wire nmi_pulse,
   input wire running,
   input wire [1:0] boot_sel,
   input wire [1:0] ctrl_sel,
   input wire [7:0] ctrl_secs,
   input wire [7:0] secs_left
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   chk_boot_arm: assert property (!$past(nrst) |=> running == ($past(boot_sel) != 2'h0)
      && secs_left == 8'h1e * $past(boot_sel)) else $error("boot arm wrong");
   chk_enable_load: assert property (running && ctrl_valid && ctrl_sel == 2'h1 && ctrl_secs != 8'h00
      |=> running && secs_left == $past(ctrl_secs)) else $error("no reload");
   chk_disable_halt: assert property (running && ctrl_valid && ctrl_sel == 2'h0
      |=> !running && !sys_restart) else $error("no halt");
   chk_restart_len: assert property ($rose(sys_restart)
      |-> sys_restart[*8] ##1 sys_restart[*8] ##1 !sys_restart) else $error("hold length wrong");
   chk_expiry_cause: assert property ($rose(sys_restart) || nmi_pulse
      |-> $past(running) && $past(secs_left) == 8'h01) else $error("early expiry");
   chk_jumper_act: assert property ($rose(sys_restart) |-> !$past(action_jumper) && !nmi_pulse)
      else $error("restart with jumper set");
   chk_nmi_only: assert property (nmi_pulse |-> $past(action_jumper) && !sys_restart ##1 !nmi_pulse)
      else $error("bad nmi pulse");
endmodule
bind srw_watchdog srw_watchdog_checker srw_watchdog_checker_i
(
   .clock(clock),
   .nrst(nrst),
   .action_jumper(action_jumper),
   .ctrl_valid(ctrl_valid),
   .sys_restart(sys_restart),
   .nmi_pulse(nmi_pulse),
   .running(running),
   .boot_sel(boot_sel),
   .ctrl_sel(ctrl_sel),
   .ctrl_secs(ctrl_secs),
   .secs_left(secs_left)
);

// file: srw_watchdog_tb.sv
// self-checking bench for the watchdog
`timescale 1ns/1ps
module srw_watchdog_tb;
   reg clock = 1'h0, nrst = 1'h0, action_jumper = 1'h0, ctrl_valid = 1'h0, retrigger = 1'h0;
   reg [1:0] boot_sel = 2'h0, ctrl_sel = 2'h0;
   reg [7:0] ctrl_secs = 8'h00;
   wire sys_restart, nmi_pulse, running;
   wire [7:0] secs_left;
   integer err_count = 0, num_checks = 0, cyc = 0, i, n;
   always #5 clock = ~clock;
   srw_watchdog #(.CYCLES_PER_SEC(10)) srw_watchdog_i
   (
      .clock(clock),
      .nrst(nrst),
      .boot_sel(boot_sel),
      .action_jumper(action_jumper),
      .ctrl_valid(ctrl_valid),
      .ctrl_sel(ctrl_sel),
      .ctrl_secs(ctrl_secs),
      .retrigger(retrigger),
      .sys_restart(sys_restart),
      .nmi_pulse(nmi_pulse),
      .running(running),
      .secs_left(secs_left)
   );
   always @(posedge clock)
      if (++cyc == 2000) give_verdict(1);
   task chk(input [7:0] got, input [7:0] exp);
      num_checks++;
      err_count += (got !== exp);
      if (got !== exp) $display("wrong value at %0t: %h %h", $time, got, exp);
   endtask
   task give_verdict(input integer extra);
      err_count += extra;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task rst(input [1:0] b);
      boot_sel = b;
      nrst = 1'h0;
      repeat (2) @(negedge clock);
      nrst = 1'h1;
      repeat (2) @(negedge clock);
   endtask
   task req(input [1:0] s, input [7:0] n);
      @(negedge clock);
      {ctrl_valid, ctrl_sel, ctrl_secs} = {1'h1, s, n};
      @(negedge clock);
      ctrl_valid = 1'h0;
   endtask
   task t_boot;
      for (i = 0; i < 4; i++)
      begin
         rst(i[1:0]);
         chk(running, i != 0);
         chk(secs_left, 8'h1e * i[1:0]);
      end
      $display("boot test end");
   endtask
   task t_expire(input j);
      rst(2'h0);
      action_jumper = j;
      req(2'h1, 8'h02);
      chk(secs_left, 8'h02);
      repeat (15) @(negedge clock);
      chk(secs_left, 8'h01);
      for (i = 0; i < 20 && (sys_restart | nmi_pulse) !== 1'h1; i++) @(negedge clock);
      chk({sys_restart, running, nmi_pulse}, {!j, 1'h0, j});
      boot_sel = 2'h1;
      n = 0;
      while (sys_restart === 1'h1 && n < 40)
      begin
         n++;
         @(negedge clock);
      end
      chk(n[7:0], j ? 8'h00 : 8'h10);
      repeat (2) @(negedge clock);
      chk(nmi_pulse, 8'h00);
      chk(running, !j);
      chk(secs_left, j ? 8'h00 : 8'h1e);
      $display("expiry test end");
   endtask
   task t_retrig;
      rst(2'h1);
      req(2'h1, 8'h03);
      req(2'h1, 8'h01);
      chk(secs_left, 8'h01);
      for (i = 0; i < 6; i++)
      begin
         repeat (7) @(negedge clock);
         retrigger = 1'h1;
         @(negedge clock);
         retrigger = 1'h0;
      end
      chk(secs_left, 8'h01);
      req(2'h0, 8'h01);
      repeat (30) @(negedge clock);
      chk({running, sys_restart}, 8'h00);
      $display("retrigger test end");
   endtask
   initial
   begin
      t_boot;
      t_expire(1'h0);
      t_expire(1'h1);
      t_retrig;
      give_verdict(0);
   end
endmodule
